// ===== dv/gpc_pads.sv
// Pad model: resolves each pin from drive, pulls and far-side level
`timescale 1ns/100ps
module gpc_pads (
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pu,
    input  wire logic [7:0] pad_pd,
    input  wire logic [7:0] ext_lvl,
    output logic      [7:0] pad_in
);
    // Driven pin shows its drive, else its pull, else the far side
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (pad_pu[i])
                pad_in[i] = 1'b1;
            else if (pad_pd[i])
                pad_in[i] = 1'b0;
            else
                pad_in[i] = ext_lvl[i];
        end
    end
endmodule

// ===== dv/gpio_port_config_defaults_tb.sv
// Self-checking bench for the eight-bit port, wired as port B
`timescale 1ns/100ps
module gpio_port_config_defaults_tb;
    localparam logic [31:0] KEY = 32'h1234_5678; // Arbitrary value
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        gate = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  dr2;
    logic [31:0] address = 32'h0000_0000;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        irq;
    logic [7:0]  pad_in, pad_out, pad_oe, pad_in_en, pad_pu, pad_pd, alt_in;
    logic [7:0]  ext_lvl = 8'h00;
    logic [7:0]  alt_out = 8'h00;
    logic [7:0]  alt_oe = 8'h00;
    logic [7:0]  q, m, v, pins;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          seed = 40418;
    logic [11:0] roff [5] = '{12'h420, 12'h510, 12'h51C, 12'h514, 12'h524};
    logic [7:0]  rexp [5] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h7F};

    // 40 MHz clock
    always #12.5 clk = ~clk;

    gpc_port #(.PORT_ID(3'h1)) dut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .clk_gate_en(gate), .address(address), .read(read), .write(write),
        .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_in_en(pad_in_en),
        .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_dr2(dr2), .pad_dr4(),
        .pad_dr8(), .pad_slr(), .alt_out(alt_out), .alt_oe(alt_oe),
        .alt_in(alt_in));

    gpc_pads pads (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
        .pad_pd(pad_pd), .ext_lvl(ext_lvl), .pad_in(pad_in));

    // ==========================================================
    // Expectations and bus tasks
    // ==========================================================
    // Base address of port id, two banks of four
    function automatic logic [31:0] base(input int id);
        return (id < 4 ? 32'h4000_4000 : 32'h4002_4000)
               + 32'(id % 4) * 32'h1000;
    endfunction

    // Masked data write result
    function automatic logic [7:0] merge(input logic [7:0] o, n, k);
        return (o & ~k) | (n & k);
    endfunction

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One Avalon transfer at offset a from port B, read data into q
    task automatic bus(input logic we, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        address <= base(1) + a;
        write <= we;
        read <= !we;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    // Verdict
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk(pad_oe, 8'h00);
        chk(pad_in_en, 8'h80);
        @(posedge clk);
        gate <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, roff[i], 0);
            chk(q, rexp[i]);
        end
        bus(1'b1, 12'h524, 0);
        bus(1'b0, 12'h524, 0);
        chk(q, 8'h7F);
        bus(1'b1, 12'h524, 8'hFF);
        bus(1'b0, 12'h524, 0);
        chk(q, 8'hFF);
        bus(1'b1, 12'h420, 0);
        bus(1'b0, 12'h420, 0);
        chk(q, 8'h80);
        bus(1'b1, 12'h520, KEY);
        bus(1'b1, 12'h420, 0);
        bus(1'b0, 12'h420, 0);
        chk(q, 8'h00);
        bus(1'b1, 12'h51C, 8'hFF);
        bus(1'b1, 12'h400, 8'hFE);
        bus(1'b1, 12'h500, 8'hFF);
        // Debug pin pulled high by its reset pull-up before it drove
        pins = 8'h80;
        for (int i = 0; i < 8; i++) begin
            m = $random(seed);
            v = $random(seed);
            bus(1'b1, {22'h0, m, 2'b00}, v);
            pins = merge(pins, v, m);
            @(posedge clk);
            #1;
            chk(pad_out & 8'hFE, pins & 8'hFE);
        end
        chk(pad_oe, 8'hFE);
        bus(1'b1, 12'h404, 0);
        bus(1'b1, 12'h408, 0);
        bus(1'b1, 12'h40C, 8'h01);
        bus(1'b1, 12'h410, 8'h01);
        ext_lvl <= 8'h01;
        repeat (8) @(posedge clk);
        #1;
        chk(irq, 1'b1);
        bus(1'b0, 12'h414, 0);
        chk(q & 8'h01, 8'h01);
        bus(1'b1, 12'h41C, 8'h01);
        repeat (3) @(posedge clk);
        #1;
        chk(irq, 1'b0);
        ext_lvl <= 8'h00;
        repeat (8) @(posedge clk);
        #1;
        chk(irq, 1'b0);
        bus(1'b1, 12'h420, 8'h01);
        alt_out <= 8'h01;
        alt_oe <= 8'h01;
        repeat (3) @(posedge clk);
        #1;
        chk({pad_oe[0], pad_out[0]}, 2'b11);
        chk(alt_in, 8'h01);
        // Clock enable low freezes the pad drive
        @(posedge clk);
        ce <= 1'b0;
        alt_oe <= 8'h00;
        repeat (3) @(posedge clk);
        #1;
        chk(pad_oe[0], 1'b1);
        @(posedge clk);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(pad_oe[0], 1'b0);
        chk(dr2, 8'hFE);
        bus(1'b0, 32'h0000_1400, 0);
        chk(q, 8'h00);
        end_of_test();
    end
endmodule

// ===== inc/gpc_irq_if.sv
// Carrier between the port core and its event detector
`timescale 1ns/100ps
interface gpc_irq_if;
    logic       run;
    logic [7:0] lvl;
    logic [7:0] sense;
    logic [7:0] both;
    logic [7:0] pol;
    logic [7:0] evt;

    modport core (output run, lvl, sense, both, pol, input evt);
    modport det  (input run, lvl, sense, both, pol, output evt);
endinterface

// ===== inc/gpc_pkg.sv
// Constants, register map and reset helpers for the eight-bit port
package gpc_pkg;

    // ==========================================================
    // Bus handshake and settling
    // ==========================================================
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam logic [1:0]  SETTLE_CLKS = 2'h3;

    // ==========================================================
    // Port base addresses
    // ==========================================================
    localparam logic [31:0] BASE_LO   = 32'h4000_4000;
    localparam logic [31:0] BASE_HI   = 32'h4002_4000;
    localparam logic [31:0] BASE_STEP = 32'h0000_1000;
    localparam logic [31:0] BASE_MASK = 32'hFFFF_F000;

    // ==========================================================
    // Register offsets inside one port
    // ==========================================================
    localparam logic [11:0] OFF_DIR   = 12'h400;
    localparam logic [11:0] OFF_ISNS  = 12'h404;
    localparam logic [11:0] OFF_IBE   = 12'h408;
    localparam logic [11:0] OFF_IEV   = 12'h40C;
    localparam logic [11:0] OFF_IM    = 12'h410;
    localparam logic [11:0] OFF_RIS   = 12'h414;
    localparam logic [11:0] OFF_MIS   = 12'h418;
    localparam logic [11:0] OFF_ICR   = 12'h41C;
    localparam logic [11:0] OFF_ALT_FUNCTION_BIT = 12'h420;
    localparam logic [11:0] OFF_DR2   = 12'h500;
    localparam logic [11:0] OFF_DR4   = 12'h504;
    localparam logic [11:0] OFF_DR8   = 12'h508;
    localparam logic [11:0] OFF_ODR   = 12'h50C;
    localparam logic [11:0] OFF_PUR   = 12'h510;
    localparam logic [11:0] OFF_PDR   = 12'h514;
    localparam logic [11:0] OFF_SLR   = 12'h518;
    localparam logic [11:0] OFF_DEN   = 12'h51C;
    localparam logic [11:0] OFF_LOCK  = 12'h520;
    localparam logic [11:0] OFF_CR    = 12'h524;

    // ==========================================================
    // Reset values and protected pins
    // ==========================================================
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_CR_FREE = 8'hFF;
    localparam logic [7:0] PROT_B      = 8'h80;
    localparam logic [7:0] PROT_C      = 8'h0F;
    localparam logic [2:0] ID_B        = 3'h1;
    localparam logic [2:0] ID_C        = 3'h2;

    // Debug pins held back from software per port
    function automatic logic [7:0] prot_mask(input logic [2:0] id);
        return (id == ID_B) ? PROT_B : (id == ID_C) ? PROT_C : RST_ZERO;
    endfunction

    // Commit reset: debug pins start non-committable
    function automatic logic [7:0] cr_reset(input logic [2:0] id);
        return RST_CR_FREE & ~prot_mask(id);
    endfunction

    // Base address of port id, two banks of four
    function automatic logic [31:0] port_base(input logic [2:0] id);
        logic [31:0] step;
        step = BASE_STEP * {30'h0000_0000, id[1:0]};
        return (id[2] ? BASE_HI : BASE_LO) + step;
    endfunction

endpackage

// ===== rtl/gpc_edge.sv
// Per-pin edge and level event detector
`timescale 1ns/100ps
module gpc_edge (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    gpc_irq_if.det    irq
);

    logic [7:0] prev;
    logic [7:0] lvl_hit;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] edge_hit;

    // ==========================================================
    // Event decode
    // ==========================================================
    // Level match, rising, falling, then sense select
    assign lvl_hit  = (irq.lvl & irq.pol) | (~irq.lvl & ~irq.pol);
    assign rise     = irq.lvl & ~prev;
    assign fall     = ~irq.lvl & prev;
    assign edge_hit = (irq.both & (rise | fall))
                    | (~irq.both & irq.pol & rise)
                    | (~irq.both & ~irq.pol & fall);
    assign irq.evt  = {8{irq.run}}
                    & ((irq.sense & lvl_hit) | (~irq.sense & edge_hit));

    // Previous pad level for edge finding
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev <= 8'h00;
        end else if (ce && irq.run) begin
            prev <= irq.lvl;
        end
    end

    AST_RISE_ONLY: assert property (
        @(posedge clk) disable iff (!rst_b)
        ((irq.evt & ~irq.sense & ~irq.both & irq.pol) & ~irq.lvl) == 8'h00)
        else $error("rising-edge pin flagged without high level");

    AST_EDGE_ONCE: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && irq.run && $past(ce) && $past(irq.run) && $past(rst_b)
        && $stable(irq.lvl) |-> (irq.evt & ~irq.sense) == 8'h00)
        else $error("edge event without a level change");

endmodule

// ===== rtl/gpc_port.sv
// Eight-bit general-purpose port with pad control and interrupts
`timescale 1ns/100ps

// Operation
// - Non-debug pins come out of reset undriven with their config cleared.
// - Alt select, pull-up and digital enable reset to the debug pins.
// - Commit resets to all ones except the debug pins, which start clear.
// - Commit bits are read-only except for the debug pins (one on port B, four on port C).
// - Bits with no pad ignore writes and read back as zero.
// - A peripheral input ignores drive strength and slew settings.
// - Edge, single, high and unmasked gives rising-edge events only.
// - Each port decodes offsets from its own base address.
// - Don't-care pad bits have no effect in their configuration.
// - Direction 0 captures the pad, direction 1 drives the data bit.
// - Protected alt select bits change only when unlocked and committed.
// - Writing one to interrupt clear drops the pending bit unless an event sets it in that same cycle.
module gpc_port #(
    parameter logic [2:0]  PORT_ID    = 3'h0,
    parameter logic [7:0]  PAD_MASK   = 8'hFF,
    parameter logic [31:0] UNLOCK_KEY = 32'h1234_5678 // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        clk_gate_en,
    input  wire logic [31:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq,
    input  wire logic [7:0]  pad_in,
    output logic      [7:0]  pad_out,
    output logic      [7:0]  pad_oe,
    output logic      [7:0]  pad_in_en,
    output logic      [7:0]  pad_pu,
    output logic      [7:0]  pad_pd,
    output logic      [7:0]  pad_dr2,
    output logic      [7:0]  pad_dr4,
    output logic      [7:0]  pad_dr8,
    output logic      [7:0]  pad_slr,
    input  wire logic [7:0]  alt_out,
    input  wire logic [7:0]  alt_oe,
    output logic      [7:0]  alt_in
);

    localparam logic [7:0]  PROT     = gpc_pkg::prot_mask(PORT_ID);
    localparam logic [7:0]  RST_PIN  = PROT;
    localparam logic [7:0]  RST_CR   = gpc_pkg::cr_reset(PORT_ID);
    localparam logic [31:0] MY_BASE  = gpc_pkg::port_base(PORT_ID);

    // Configuration state
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] isense;
    logic [7:0] ibe;
    logic [7:0] iev;
    logic [7:0] im;
    logic [7:0] ris;
    logic [7:0] alt_function_bit;
    logic [7:0] dr2;
    logic [7:0] dr4;
    logic [7:0] dr8;
    logic [7:0] open_drain_bit;
    logic [7:0] pull_up_bit;
    logic [7:0] pull_down_bit;
    logic [7:0] slew_limit_bit;
    logic [7:0] digital_enable_bit;
    logic [7:0] cr;
    logic       unlocked;
    logic [1:0] settle;

    // ==========================================================
    // Clock gating and settling
    // ==========================================================
    logic run;
    logic live;

    // Port logic runs only with its clock bit set
    assign run  = ce & clk_gate_en;
    assign live = (settle == gpc_pkg::SETTLE_CLKS);

    // Settling counter after the port clock is enabled
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            settle <= 2'h0;
        end else if (ce) begin
            if (!clk_gate_en) begin
                settle <= 2'h0;
            end else if (!live) begin
                settle <= settle + 2'h1;
            end
        end
    end

    // ==========================================================
    // Bus decode
    // ==========================================================
    logic        req;
    logic        sel;
    logic        acc_wr;
    logic [11:0] off;
    logic [7:0]  wd;
    logic [7:0]  amask;
    logic        hit_data;

    // Own base match, one word per register
    assign req      = read | write;
    assign sel      = (address & gpc_pkg::BASE_MASK) == MY_BASE;
    assign off      = {address[11:2], 2'b00};
    assign hit_data = (off[11:10] == 2'b00);
    assign amask    = address[9:2];
    assign wd       = writedata[7:0];
    // Commit on the accepting edge; early accesses dropped
    assign acc_wr   = write & ~waitrequest & byteenable[0]
                    & sel & live & ce;

    // Per-register write strobes
    function automatic logic wr_at(input logic [11:0] o);
        return acc_wr && (off == o);
    endfunction

    logic wr_dir;
    logic wr_isns;
    logic wr_ibe;
    logic wr_iev;
    logic wr_im;
    logic wr_icr;
    logic wr_afs;
    logic wr_dr2;
    logic wr_dr4;
    logic wr_dr8;
    logic wr_odr;
    logic wr_pur;
    logic wr_pdr;
    logic wr_slr;
    logic wr_den;
    logic wr_lock;
    logic wr_cr;

    assign wr_dir  = wr_at(gpc_pkg::OFF_DIR);
    assign wr_isns = wr_at(gpc_pkg::OFF_ISNS);
    assign wr_ibe  = wr_at(gpc_pkg::OFF_IBE);
    assign wr_iev  = wr_at(gpc_pkg::OFF_IEV);
    assign wr_im   = wr_at(gpc_pkg::OFF_IM);
    assign wr_icr  = wr_at(gpc_pkg::OFF_ICR);
    assign wr_afs  = wr_at(gpc_pkg::OFF_ALT_FUNCTION_BIT);
    assign wr_dr2  = wr_at(gpc_pkg::OFF_DR2);
    assign wr_dr4  = wr_at(gpc_pkg::OFF_DR4);
    assign wr_dr8  = wr_at(gpc_pkg::OFF_DR8);
    assign wr_odr  = wr_at(gpc_pkg::OFF_ODR);
    assign wr_pur  = wr_at(gpc_pkg::OFF_PUR);
    assign wr_pdr  = wr_at(gpc_pkg::OFF_PDR);
    assign wr_slr  = wr_at(gpc_pkg::OFF_SLR);
    assign wr_den  = wr_at(gpc_pkg::OFF_DEN);
    assign wr_lock = wr_at(gpc_pkg::OFF_LOCK);
    assign wr_cr   = wr_at(gpc_pkg::OFF_CR);

    // ==========================================================
    // Write data shaping
    // ==========================================================
    logic [7:0] wpad;
    logic [7:0] wd_mask;
    logic [7:0] afs_ok;
    logic [7:0] pad_cap;
    logic [7:0] icr_clr;
    logic [7:0] alt_function_bit_prot;
    logic [7:0] gpio_oe;

    // Unconnected bits never take a write
    assign wpad    = wd & PAD_MASK;
    // Masked data write through address bits
    assign wd_mask = {8{acc_wr & hit_data}} & amask & PAD_MASK;
    // Protected alt bits need unlock and commit
    assign afs_ok  = ~PROT | ({8{unlocked}} & cr);
    // Pad value reaches logic only with digital enable
    assign pad_cap = pad_in & digital_enable_bit;
    assign icr_clr = {8{wr_icr}} & wpad;
    assign alt_function_bit_prot = alt_function_bit & PROT;
    assign gpio_oe    = dir & digital_enable_bit;

    // Next value of the data register
    logic [7:0] next_data;
    assign next_data = (dir & ((wd_mask & wpad) | (~wd_mask & data)))
                     | (~dir & pad_cap);

    // Simple configuration registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            data   <= gpc_pkg::RST_ZERO;
            dir    <= gpc_pkg::RST_ZERO;
            isense <= gpc_pkg::RST_ZERO;
            ibe    <= gpc_pkg::RST_ZERO;
            iev    <= gpc_pkg::RST_ZERO;
            im     <= gpc_pkg::RST_ZERO;
            dr2    <= gpc_pkg::RST_ZERO;
            dr4    <= gpc_pkg::RST_ZERO;
            dr8    <= gpc_pkg::RST_ZERO;
            open_drain_bit    <= gpc_pkg::RST_ZERO;
            pull_down_bit    <= gpc_pkg::RST_ZERO;
            slew_limit_bit    <= gpc_pkg::RST_ZERO;
        end else if (run) begin
            data   <= next_data;
            dir    <= wr_dir  ? wpad : dir;
            isense <= wr_isns ? wpad : isense;
            ibe    <= wr_ibe  ? wpad : ibe;
            iev    <= wr_iev  ? wpad : iev;
            im     <= wr_im   ? wpad : im;
            dr2    <= wr_dr2  ? wpad : dr2;
            dr4    <= wr_dr4  ? wpad : dr4;
            dr8    <= wr_dr8  ? wpad : dr8;
            open_drain_bit    <= wr_odr  ? wpad : open_drain_bit;
            pull_down_bit    <= wr_pdr  ? wpad : pull_down_bit;
            slew_limit_bit    <= wr_slr  ? wpad : slew_limit_bit;
        end
    end

    // Debug-pin defaults, commit and lock
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alt_function_bit    <= RST_PIN;
            pull_up_bit      <= RST_PIN;
            digital_enable_bit      <= RST_PIN;
            cr       <= RST_CR;
            unlocked <= 1'b0;
        end else if (run) begin
            if (wr_afs) begin
                alt_function_bit <= (afs_ok & wpad) | (~afs_ok & alt_function_bit);
            end
            pull_up_bit <= wr_pur ? (wpad | (pull_up_bit & ~PAD_MASK)) : pull_up_bit;
            digital_enable_bit <= wr_den ? (wpad | (digital_enable_bit & ~PAD_MASK)) : digital_enable_bit;
            if (wr_cr) begin
                cr <= (wd & PROT) | (cr & ~PROT);
            end
            if (wr_lock) begin
                unlocked <= (writedata == UNLOCK_KEY);
            end
        end
    end

    // ==========================================================
    // Interrupts
    // ==========================================================
    gpc_irq_if irq_bus ();
    logic [7:0] next_ris;
    logic       irq_any;

    assign irq_bus.run   = run;
    assign irq_bus.lvl   = pad_cap;
    assign irq_bus.sense = isense & PAD_MASK;
    assign irq_bus.both  = ibe;
    assign irq_bus.pol   = iev;

    gpc_edge u_edge (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .irq   (irq_bus.det)
    );

    // Set wins over a same-cycle clear
    assign next_ris = (ris & ~icr_clr) | irq_bus.evt;
    assign irq_any  = |(next_ris & im);

    // Sticky status and level interrupt
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ris <= gpc_pkg::RST_ZERO;
            irq <= 1'b0;
        end else if (run) begin
            ris <= next_ris;
            irq <= irq_any;
        end
    end

    // ==========================================================
    // Pad drive
    // ==========================================================
    logic [7:0] drv_val;
    logic [7:0] drv_en;
    logic [7:0] next_oe;
    logic [7:0] next_out;
    logic [7:0] out_cap;

    // Alt path takes over value and enable, direction unused
    assign drv_val  = (alt_function_bit & alt_out) | (~alt_function_bit & data);
    assign drv_en   = ((alt_function_bit & alt_oe) | (~alt_function_bit & dir)) & digital_enable_bit;
    // Open drain only pulls low
    assign next_out = drv_val & ~open_drain_bit;
    assign next_oe  = drv_en & (~open_drain_bit | ~drv_val);
    // Strength and slew only where the pin drives
    assign out_cap  = drv_en;

    // Registered pad controls
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pad_out   <= 8'h00;
            pad_oe    <= 8'h00;
            pad_in_en <= RST_PIN;
            pad_pu    <= RST_PIN;
            pad_pd    <= 8'h00;
            pad_dr2   <= 8'h00;
            pad_dr4   <= 8'h00;
            pad_dr8   <= 8'h00;
            pad_slr   <= 8'h00;
            alt_in    <= 8'h00;
        end else if (run) begin
            pad_out   <= next_out;
            pad_oe    <= next_oe;
            pad_in_en <= digital_enable_bit;
            pad_pu    <= pull_up_bit & ~open_drain_bit;
            pad_pd    <= pull_down_bit & ~open_drain_bit;
            pad_dr2   <= dr2 & out_cap;
            pad_dr4   <= dr4 & out_cap;
            pad_dr8   <= dr8 & out_cap;
            pad_slr   <= slew_limit_bit & out_cap;
            alt_in    <= pad_cap & alt_function_bit;
        end
    end

    // ==========================================================
    // Read back and handshake
    // ==========================================================
    logic [7:0] rd_mux;
    logic [7:0] rd_reg;

    assign rd_reg =
        (off == gpc_pkg::OFF_DIR)   ? dir      :
        (off == gpc_pkg::OFF_ISNS)  ? isense   :
        (off == gpc_pkg::OFF_IBE)   ? ibe      :
        (off == gpc_pkg::OFF_IEV)   ? iev      :
        (off == gpc_pkg::OFF_IM)    ? im       :
        (off == gpc_pkg::OFF_RIS)   ? ris      :
        (off == gpc_pkg::OFF_MIS)   ? ris & im :
        (off == gpc_pkg::OFF_ALT_FUNCTION_BIT) ? alt_function_bit    :
        (off == gpc_pkg::OFF_DR2)   ? dr2      :
        (off == gpc_pkg::OFF_DR4)   ? dr4      :
        (off == gpc_pkg::OFF_DR8)   ? dr8      :
        (off == gpc_pkg::OFF_ODR)   ? open_drain_bit      :
        (off == gpc_pkg::OFF_PUR)   ? pull_up_bit      :
        (off == gpc_pkg::OFF_PDR)   ? pull_down_bit      :
        (off == gpc_pkg::OFF_SLR)   ? slew_limit_bit      :
        (off == gpc_pkg::OFF_DEN)   ? digital_enable_bit      :
        (off == gpc_pkg::OFF_LOCK)  ? {7'h00, ~unlocked} :
        (off == gpc_pkg::OFF_CR)    ? cr       : 8'h00;
    // Missing pads, unmapped or early reads give zero
    assign rd_mux = (sel && live)
                  ? ((hit_data ? (data & amask) : rd_reg) & PAD_MASK)
                  : 8'h00;

    // One wait cycle, then answer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else if (ce) begin
            waitrequest <= ~(req & waitrequest);
            if (read && waitrequest) begin
                readdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    AST_RST_UNDRIVEN: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> pad_oe == 8'h00 && pad_pd == 8'h00
                         && dir == 8'h00)
        else $error("pins driven right after reset");

    AST_RST_DEBUG: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> alt_function_bit == PROT && pull_up_bit == PROT && digital_enable_bit == PROT)
        else $error("debug pin defaults wrong after reset");

    AST_RST_COMMIT: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> cr == RST_CR && !unlocked)
        else $error("commit reset value wrong");

    AST_COMMIT_RO: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cr & ~PROT) == (RST_CR & ~PROT))
        else $error("read-only commit bit changed");

    AST_NO_PAD: assert property (
        @(posedge clk) disable iff (!rst_b)
        ((dir | im | open_drain_bit | pull_down_bit) & ~PAD_MASK) == 8'h00)
        else $error("unconnected bit took a write");

    AST_LOCKED_ALT_FUNCTION_BIT: assert property (
        @(posedge clk) disable iff (!rst_b)
        !unlocked |=> $stable(alt_function_bit_prot))
        else $error("protected alt bit changed while locked");

    AST_GPIO_OE: assert property (
        @(posedge clk) disable iff (!rst_b)
        run && alt_function_bit == 8'h00 && open_drain_bit == 8'h00
        |=> pad_oe == $past(gpio_oe))
        else $error("gpio drive does not follow direction");

    AST_ICR_CLEAR: assert property (
        @(posedge clk) disable iff (!rst_b)
        run && (icr_clr != 8'h00) && (irq_bus.evt == 8'h00)
        |=> (ris & $past(icr_clr)) == 8'h00)
        else $error("pending bit survived its clear");

    AST_ANSWER: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && req && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one wait cycle");

    AST_SETTLE: assert property (
        @(posedge clk) disable iff (!rst_b)
        ce && !clk_gate_en |=> !live [*3])
        else $error("port live before settling");

endmodule
